// file: logic/dsr_result_latch.sv
// cycle counter, result capture and display drive of a dual-slope voltmeter
`timescale 1ns/1ps
`include "dsr_defines.svh"
module dsr_result_latch (
  input  wire logic                     clock,
  input  wire logic                     srst,
  input  wire dsr_pkg::dsr_bus_req_type bus_req,
  output logic      [31:0]              rdata_q,
  input  wire logic                     comparator,
  input  wire logic                     polarity_neg,
  input  wire logic [2:0]               range_n,
  output logic      [20:0]              seg_q,
  output logic                          half_one_q,
  output logic                          half_fill_q,
  output logic      [2:0]               dp_q,
  output logic                          sign_q,
  output logic                          ref_switch_q,
  output logic      [1:0]               phase_q,
  output logic                          irq_q
);

  // four-digit bcd increment with decimal carry
  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (r[i*4 +: 4] == 4'h9) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    return a == ofs;
  endfunction

  // ---------------------------------------------------------------- state
  logic [15:0]           cnt_q;
  logic [15:0]           cnt_d;
  logic                  cmp_q;
  logic                  pol_q;
  logic                  done_q;
  logic                  sync_q;
  logic                  sync_dly_q;
  dsr_pkg::dsr_store_type store_q;
  dsr_pkg::dsr_store_type store_d;
  logic [2:0]            status_q;
  logic [2:0]            status_d;
  logic [2:0]            mask_q;
  logic                  run_q;
  dsr_pkg::dsr_phase_type phase_st;

  // ---------------------------------------------------------------- decode
  wire        wr_status  = bus_req.wr && hit(bus_req.addr, `DSR_OFS_STATUS);
  wire        wr_mask    = bus_req.wr && hit(bus_req.addr, `DSR_OFS_MASK);
  wire        wr_ctrl    = bus_req.wr && hit(bus_req.addr, `DSR_OFS_CTRL);
  // the count is bcd, so the last integration state is 5999, not a binary minus one
  wire        at_integ   = run_q && (cnt_q == `DSR_CNT_INTEG_LAST);
  wire        at_wrap    = run_q && (cnt_q == `DSR_CNT_WRAP);
  wire        in_integ   = cnt_q < `DSR_CNT_INTEG_END;
  wire        cmp_fall   = cmp_q && !comparator;
  wire        in_ref     = !in_integ && !done_q && (cnt_q < `DSR_CNT_COMPARE);
  wire        ovl_now    = !done_q && (cnt_q >= `DSR_CNT_OVERLOAD);
  // sync flop stays set until wrap; only its first cycle may load, otherwise
  // the shown reading would keep running on after the comparison
  wire        xfer_pulse = sync_q && !sync_dly_q;
  // the transfer pulse gives one load; overload keeps loading each count
  wire        load_en    = (xfer_pulse || ovl_now) && !in_integ;
  wire [3:0]  th_adj     = cnt_q[15:12] - `DSR_THOUSANDS_OFS;
  wire [2:0]  ev         = {at_integ, ovl_now && !phase_q[1], xfer_pulse};
  wire [2:0]  mask_d     = wr_mask ? bus_req.wdata[2:0] : mask_q;

  assign cnt_d = at_wrap ? 16'h0000 : (run_q ? bcd_inc(cnt_q) : cnt_q);

  always_comb begin
    case ({ovl_now, done_q, in_integ})
      3'b001:  phase_st = dsr_pkg::DSR_INTEG;
      3'b000:  phase_st = dsr_pkg::DSR_REF;
      3'b010:  phase_st = dsr_pkg::DSR_IDLE;
      3'b100:  phase_st = dsr_pkg::DSR_OVL;
      default: phase_st = dsr_pkg::DSR_IDLE;
    endcase
  end

  // store takes the reading relative to the end of integration, in bcd
  always_comb begin
    store_d = store_q;
    if (load_en) begin
      store_d.neg = pol_q;
      store_d.d3  = th_adj;
      store_d.d2  = cnt_q[11:8];
      store_d.d1  = cnt_q[7:4];
      store_d.d0  = cnt_q[3:0];
    end
  end

  // set wins over a write-one clear in the same cycle
  assign status_d = (status_q & ~(wr_status ? bus_req.wdata[2:0] : 3'h0)) | ev;

  // ---------------------------------------------------------------- counter
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_q <= 16'h0000;
      cmp_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      cmp_q <= comparator;
    end
  end

  // phase outputs: low bit from 6000 on, both high from 8002 on in overload
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q[0] <= (cnt_d >= `DSR_CNT_INTEG_END);
      phase_q[1] <= (phase_st == dsr_pkg::DSR_OVL) && !at_wrap;
    end
  end

  // polarity is caught with the final integration count and held until the next one
  always_ff @(posedge clock) begin
    if (srst) begin
      pol_q <= 1'b0;
    end else if (at_integ) begin
      pol_q <= polarity_neg;
    end
  end

  // the comparison flop is asynchronous in spirit; sync flop retimes it
  always_ff @(posedge clock) begin
    if (srst || at_wrap) begin
      done_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      if (in_ref && cmp_fall) begin
        done_q <= 1'b1;
      end
      sync_q <= done_q;
    end
  end

  // delayed copy marks the first cycle of the sync flop as the transfer pulse
  always_ff @(posedge clock) begin
    if (srst) begin
      sync_dly_q <= 1'b0;
    end else begin
      sync_dly_q <= sync_q;
    end
  end

  // reference current flows until the comparison or the overload limit
  always_ff @(posedge clock) begin
    if (srst) begin
      ref_switch_q <= 1'b0;
    end else begin
      ref_switch_q <= in_ref && !cmp_fall && run_q;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      store_q <= '0;
    end else begin
      store_q <= store_d;
    end
  end

  // ---------------------------------------------------------------- display
  logic [20:0] seg_d;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_dec
      dsr_seg_decoder u_dec (
        .bcd (store_q[g*4 +: 4]),
        .seg (seg_d[g*7 +: 7])
      );
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (srst) begin
      seg_q       <= 21'h000000;
      half_one_q  <= 1'b0;
      half_fill_q <= 1'b0;
      dp_q        <= 3'h0;
      sign_q      <= 1'b0;
    end else begin
      seg_q       <= seg_d;
      half_one_q  <= 1'b1;
      half_fill_q <= (store_q.d3 == 4'h0);
      dp_q        <= ~range_n;
      sign_q      <= store_q.neg;
    end
  end

  // ---------------------------------------------------------------- registers
  always_ff @(posedge clock) begin
    if (srst) begin
      status_q <= 3'h0;
      mask_q   <= `DSR_MASK_RST;
      run_q    <= `DSR_CTRL_RST;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      // irq uses the mask being written, so it never lags an unmasked bit
      irq_q    <= |(status_d & mask_d);
      mask_q   <= mask_d;
      if (wr_ctrl) begin
        run_q <= bus_req.wdata[`DSR_CTRL_RUN];
      end
    end
  end

  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h00000000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `DSR_OFS_STATUS: rdata_d = {29'h0, status_q};
        `DSR_OFS_MASK:   rdata_d = {29'h0, mask_q};
        `DSR_OFS_RESULT: rdata_d = {15'h0, store_q};
        `DSR_OFS_CTRL:   rdata_d = {31'h0, run_q};
        `DSR_OFS_COUNT:  rdata_d = {12'h0, phase_st, phase_q, cnt_q};
        default:         rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------- checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_cmp_seen;
    in_ref && cmp_fall;
  endsequence

  sequence s_transfer;
    done_q && !sync_q ##1 sync_q;
  endsequence

  sequence s_ovl_start;
    ovl_now && !phase_q[1];
  endsequence

  pol_capture_a: assert property ($rose(phase_q[0]) |-> pol_q == $past(polarity_neg))
    else $error("polarity not captured at end of integration");

  pol_hold_a: assert property (!at_integ |=> $stable(pol_q))
    else $error("polarity changed outside end of integration");

  cmp_done_a: assert property (s_cmp_seen |=> done_q && !ref_switch_q)
    else $error("comparison did not set flag or close switch");

  sync_xfer_a: assert property (s_cmp_seen ##1 1'b1 |-> s_transfer)
    else $error("sync flop did not follow the comparison");

  xfer_copy_a: assert property (xfer_pulse |=> store_q.d2 == $past(cnt_q[11:8])
                                && store_q.d0 == $past(cnt_q[3:0]))
    else $error("transfer did not copy counter");

  integ_hold_a: assert property (in_integ |=> $stable(store_q))
    else $error("store changed during integration");

  ovl_phase_a: assert property (ovl_now && !at_wrap |=> phase_q == 2'b11)
    else $error("overload not shown on phase outputs");

  ovl_flicker_a: assert property (ovl_now |=> store_q.d0 == $past(cnt_q[3:0]))
    else $error("store not reloaded during overload");

  sign_drive_a: assert property (load_en ##1 1'b1 |=> sign_q == $past(pol_q, 2))
    else $error("sign segment does not follow stored polarity");

  dp_range_a: assert property (!range_n[0] |=> dp_q[0])
    else $error("smallest range did not light decimal point");

  irq_level_a: assert property (|(status_q & mask_q) |-> irq_q)
    else $error("interrupt low with unmasked status set");

  half_digit_a: assert property (1'b1 |=> half_one_q &&
                                 half_fill_q == ($past(store_q.d3) == 4'h0))
    else $error("half digit not driven from stored top digit");

  sign_dark_a: assert property (!store_q.neg |=> !sign_q)
    else $error("sign segment lit for positive reading");

  xfer_once_a: assert property (xfer_pulse |=> !xfer_pulse)
    else $error("transfer pulse longer than one cycle");

  ref_off_a: assert property (done_q |-> !ref_switch_q)
    else $error("reference current flows after comparison");

  ref_limit_a: assert property (cnt_q >= `DSR_CNT_COMPARE |=> !ref_switch_q)
    else $error("reference current flows past the comparison limit");

  ovl_start_a: assert property (s_ovl_start |=> status_q[`DSR_EV_OVERLOAD] && phase_q[1])
    else $error("overload start not flagged");

  wrap_clear_a: assert property (at_wrap |=> !done_q && !sync_q)
    else $error("comparison flags not cleared at wrap");

  ready_flag_a: assert property (xfer_pulse |=> status_q[`DSR_EV_READING])
    else $error("transfer did not flag a new reading");

  integ_end_a: assert property ($rose(phase_q[0]) |-> cnt_q == `DSR_CNT_INTEG_END)
    else $error("phase output rose away from end of integration");

  store_neg_a: assert property (xfer_pulse |=> store_q.neg == $past(pol_q))
    else $error("polarity not loaded with the transfer");

endmodule // dsr_result_latch

// file: logic/dsr_defines.svh
// constants for the dual-slope result latch and display block
`ifndef DSR_DEFINES_SVH
`define DSR_DEFINES_SVH

// register byte offsets
`define DSR_OFS_STATUS   5'h00
`define DSR_OFS_MASK     5'h04
`define DSR_OFS_RESULT   5'h08
`define DSR_OFS_CTRL     5'h0c
`define DSR_OFS_COUNT    5'h10

// status and mask bit positions
`define DSR_EV_READING   0
`define DSR_EV_OVERLOAD  1
`define DSR_EV_POLARITY  2
`define DSR_EV_WIDTH     3

// control bit positions and reset values
`define DSR_CTRL_RUN     0
`define DSR_CTRL_RST     1'h1
`define DSR_MASK_RST     3'h0

// counter states, bcd coded so they compare like binary
`define DSR_CNT_INTEG_END 16'h6000
`define DSR_CNT_INTEG_LAST 16'h5999
`define DSR_CNT_COMPARE   16'h8000
`define DSR_CNT_OVERLOAD  16'h8001
`define DSR_CNT_WRAP      16'h9999
`define DSR_THOUSANDS_OFS 4'h6

`endif

// file: logic/dsr_pkg.sv
// types shared by the dual-slope result latch and display block
package dsr_pkg;

  typedef enum logic [1:0] {
    DSR_INTEG = 2'b00,
    DSR_REF   = 2'b01,
    DSR_IDLE  = 2'b10,
    DSR_OVL   = 2'b11
  } dsr_phase_type;

  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dsr_bus_req_type;

  typedef struct packed {
    logic       neg;
    logic [3:0] d3;
    logic [3:0] d2;
    logic [3:0] d1;
    logic [3:0] d0;
  } dsr_store_type;

endpackage

// file: logic/dsr_seg_decoder.sv
// bcd 8421 to seven-segment decoder, segment order g f e d c b a
`timescale 1ns/1ps
module dsr_seg_decoder (
  input  wire logic [3:0] bcd,
  output logic      [6:0] seg
);

  // a set bit grounds the cathode, so the segment lights
  always_comb begin
    case (bcd)
      4'h0:    seg = 7'h3f;
      4'h1:    seg = 7'h06;
      4'h2:    seg = 7'h5b;
      4'h3:    seg = 7'h4f;
      4'h4:    seg = 7'h66;
      4'h5:    seg = 7'h6d;
      4'h6:    seg = 7'h7d;
      4'h7:    seg = 7'h07;
      4'h8:    seg = 7'h7f;
      4'h9:    seg = 7'h6f;
      default: seg = 7'h00; // codes above nine stay dark
    endcase
  end

endmodule // dsr_seg_decoder

// file: sim/dsr_analog_model.sv
// integrator and comparator model facing the result latch
`timescale 1ns/1ps
module dsr_analog_model (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        ref_switch,
  input  wire logic [1:0]  phase,
  input  wire logic [15:0] ref_counts,
  output logic             comparator
);
  logic [15:0] left_q;

  // the charge only drains while reference current flows, so a stuck switch never
  // produces a crossing; after the crossing the output stays low until integration
  always_ff @(posedge clock) begin
    if (srst || !phase[0]) begin
      left_q     <= ref_counts;
      comparator <= 1'b1;
    end else if (ref_switch && left_q != 16'h0) begin
      left_q <= left_q - 16'h1;
    end else if (ref_switch) begin
      comparator <= 1'b0;
    end
  end
endmodule // dsr_analog_model

// file: sim/tb_dsr_result_latch.sv
// self-checking bench for the result latch and display block
`timescale 1ns/1ps
`include "dsr_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
`define WAITC(c, lim) begin for (n = 0; n < lim && (c) !== 1'b1; n++) @(negedge clock); \
  if (n >= lim) begin err_total++; end_of_test(); end end
module tb_dsr_result_latch;
  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] exp;
    logic [2:0]  range_n;
    logic [2:0]  dp;
  } dsr_row_type;

  localparam logic [6:0] seg_pat [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                                          7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  localparam dsr_row_type rows [5] = '{
    '{`DSR_OFS_CTRL,   32'h1, 3'b110, 3'b001},
    '{`DSR_OFS_MASK,   32'h0, 3'b101, 3'b010},
    '{`DSR_OFS_RESULT, 32'h0, 3'b011, 3'b100},
    '{`DSR_OFS_STATUS, 32'h0, 3'b010, 3'b101},
    '{5'h14,           32'h0, 3'b111, 3'b000}};

  logic                     clock = 1'b0;
  logic                     srst = 1'b1;
  dsr_pkg::dsr_bus_req_type req = '0;
  logic                     polarity_neg = 1'b0;
  logic [2:0]               range_n = 3'b111;
  logic [15:0]              ref_counts = 16'h04d2;
  logic                     comparator;
  logic [31:0]              rdata_q;
  logic [20:0]              seg_q;
  logic                     half_one_q;
  logic                     half_fill_q;
  logic [2:0]               dp_q;
  logic                     sign_q;
  logic                     ref_switch_q;
  logic [1:0]               phase_q;
  logic                     irq_q;
  logic [31:0]              d;
  logic [20:0]              s1;
  int                       checks = 0;
  int                       err_total = 0;
  int                       n;

  always #5 clock = ~clock;

  dsr_result_latch dsr_result_latch_i (
    .clock(clock), .srst(srst), .bus_req(req), .rdata_q(rdata_q),
    .comparator(comparator), .polarity_neg(polarity_neg), .range_n(range_n),
    .seg_q(seg_q), .half_one_q(half_one_q), .half_fill_q(half_fill_q), .dp_q(dp_q),
    .sign_q(sign_q), .ref_switch_q(ref_switch_q), .phase_q(phase_q), .irq_q(irq_q));

  dsr_analog_model dsr_analog_model_i (
    .clock(clock), .srst(srst), .ref_switch(ref_switch_q), .phase(phase_q),
    .ref_counts(ref_counts), .comparator(comparator));

  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [31:0] w);
    @(posedge clock);
    req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [31:0] q);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    @(negedge clock);
    q = rdata_q;
  endtask

  // the crossing is seen a couple of counts after the model drains, hence the margin
  task automatic check_reading(input logic [31:0] r, input int k, input logic neg);
    int v;
    v = r[15:12] * 1000 + r[11:8] * 100 + r[7:4] * 10 + r[3:0];
    `CHK(v >= k && v <= k + 4, 1'b1)
    `CHK(r[16], neg)
    `CHK(sign_q, neg)
    `CHK(seg_q, {seg_pat[r[11:8]], seg_pat[r[7:4]], seg_pat[r[3:0]]})
    `CHK(half_fill_q, r[15:12] == 4'h0)
  endtask

  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(negedge clock);
    `CHK(half_one_q, 1'b1)
    foreach (rows[i]) begin
      @(posedge clock);
      range_n <= rows[i].range_n;
      rd_reg(rows[i].addr, d);
      `CHK(d, rows[i].exp)
      `CHK(dp_q, rows[i].dp)
    end
    wr_reg(`DSR_OFS_MASK, 32'h1);
    `WAITC(irq_q, 12000)
    rd_reg(`DSR_OFS_RESULT, d);
    check_reading(d, 1234, 1'b0);
    `CHK(ref_switch_q, 1'b0)
    wr_reg(`DSR_OFS_STATUS, 32'h1);
    repeat (2) @(negedge clock);
    `CHK(irq_q, 1'b0)
    s1 = seg_q;
    `WAITC(phase_q[0] === 1'b0, 4000)
    @(posedge clock);
    polarity_neg <= 1'b1;
    ref_counts <= 16'h07c6;
    `WAITC(phase_q[0], 7000)
    `CHK(seg_q, s1)
    @(posedge clock);
    polarity_neg <= 1'b0;
    `WAITC(irq_q, 3000)
    rd_reg(`DSR_OFS_RESULT, d);
    check_reading(d, 1990, 1'b1);
    wr_reg(`DSR_OFS_STATUS, 32'h1);
    `WAITC(phase_q[0] === 1'b0, 4000)
    @(posedge clock);
    ref_counts <= 16'h1388;
    `WAITC(phase_q === 2'b11, 9000)
    @(negedge clock);
    s1 = seg_q;
    @(negedge clock);
    `CHK(seg_q !== s1, 1'b1)
    rd_reg(`DSR_OFS_COUNT, d);
    `CHK(d[17:16], 2'b11)
    `CHK(d[15:0] >= `DSR_CNT_OVERLOAD, 1'b1)
    rd_reg(`DSR_OFS_STATUS, d);
    `CHK(d[`DSR_EV_OVERLOAD], 1'b1)
    `CHK(irq_q, 1'b0)
    end_of_test();
  end
endmodule // tb_dsr_result_latch
